// file: rtl/psmu_byte_reg.sv
`timescale 1ns/1ns
`default_nettype none

// One stored byte with optional write-once lock and hardware set inputs
module psmu_byte_reg
  import psmu_pkg::*;
#(
  parameter logic [7:0] RST_VAL    = 8'h00,  // Value after reset
  parameter bit         WRITE_ONCE = 1'b0    // Lock after first write
) (
  input  wire logic        ref_clk_i,  // CPU clock
  input  wire logic        rst_i,      // Synchronous reset, active high
  input  wire logic        wr_en_i,    // Accepted write this cycle
  input  wire logic [7:0]  wr_val_i,   // Full byte to store
  input  wire logic [7:0]  set_i,      // Hardware set bits
  output logic [7:0]       q_o         // Stored value
);

  logic [7:0] q_reg;        // Stored byte
  logic [7:0] q_next;
  logic       locked_reg;   // First write seen since reset
  logic       locked_next;

  // Next value; set bits are ORed last so an event beats a clearing write
  always_comb begin
    q_next      = q_reg;
    locked_next = locked_reg;
    if (wr_en_i && !(WRITE_ONCE && locked_reg)) begin
      q_next      = wr_val_i;
      locked_next = 1'b1;
    end
    q_next = q_next | set_i;
  end

  // State registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q_reg      <= RST_VAL;
      locked_reg <= 1'b0;
    end else begin
      q_reg      <= q_next;
      locked_reg <= locked_next;
    end
  end

  assign q_o = q_reg;

endmodule // psmu_byte_reg

`default_nettype wire

// file: rtl/psmu_decode.sv
`timescale 1ns/1ns
`default_nettype none

// Address to table index; one hit at most since addresses are unique
module psmu_decode
  import psmu_pkg::*;
(
  input  wire logic [15:0]     addr_i,  // Effective byte address
  output logic                 hit_o,   // Address is a table byte
  output logic [IDXW-1:0]      idx_o    // Index of that byte
);

  // Linear search; small table keeps this a shallow compare tree
  always_comb begin
    hit_o = 1'b0;
    idx_o = '0;
    for (int i = 0; i < NREG; i++) begin
      if (addr_i == REG_ADDR[i]) begin
        hit_o = 1'b1;
        idx_o = IDXW'(i);
      end
    end
  end

endmodule // psmu_decode

`default_nettype wire

// file: rtl/psmu_pkg.sv
package psmu_pkg;

  // Table geometry
  localparam int NREG     = 43;   // Byte registers held in storage cells
  localparam int IDXW     = 6;    // Width of a table index
  localparam int BYTE_W   = 8;
  localparam int WORD_W   = 16;
  localparam int BIT_IW   = 3;    // Width of a bit number
  localparam int IRQ_BYTES = 3;   // Request flag bytes fed by peripheral events
  localparam int IRQ_W    = IRQ_BYTES * BYTE_W;

  // Access width of one CPU request
  typedef enum logic [1:0] {
    PSMU_SZ_BIT,
    PSMU_SZ_BYTE,
    PSMU_SZ_WORD
  } psmu_size_t;

  // Registers that live outside the byte table
  localparam logic [15:0] ADDR_CMP_B       = 16'hff64;  // Word-only compare
  localparam logic [15:0] ADDR_CNT_C       = 16'hff7a;  // Counter, read only
  localparam logic [15:0] ADDR_ASYNC_STAT  = 16'hffa1;  // Status, read only
  localparam logic [15:0] ADDR_SYNC_SHIFT  = 16'hffb2;  // Shift data, read only

  // Eight-bit special-register addressing: page and the hole it cannot reach
  localparam logic [7:0]  SFR_PAGE     = 8'hff;
  localparam logic [7:0]  SFR_GAP_LO   = 8'hd0;
  localparam logic [7:0]  SFR_GAP_HI   = 8'hdf;

  // Table indexes that the logic names directly
  localparam int IDX_PF_A          = 0;
  localparam int IDX_PF_B          = 1;
  localparam int IDX_PRESCALE      = 3;
  localparam int IDX_KEY_WAKEUP    = 19;
  localparam int IDX_SSA_CLK_SEL   = 27;
  localparam int IDX_IRQ_REQ_A_LO  = 29;
  localparam int IDX_MASK_A_LO     = 32;
  localparam int IDX_PRIO_A_LO     = 35;
  localparam int IDX_MEM_SIZE      = 38;
  localparam int IDX_XRAM_SIZE     = 39;
  localparam int IDX_OSC_SETTLE    = 41;
  localparam int IDX_CPU_CLK       = 42;

  // Byte addresses, table order
  localparam logic [15:0] REG_ADDR [NREG] = '{
    16'hff58, 16'hff59, 16'hff60, 16'hff61, 16'hff62, 16'hff63, 16'hff68, 16'hff70,
    16'hff71, 16'hff73, 16'hff74, 16'hff76, 16'hff77, 16'hff79, 16'hff80, 16'hff81,
    16'hff82, 16'hff83, 16'hff8a, 16'hff8f, 16'hff90, 16'hff91, 16'hff92, 16'hffa0,
    16'hffa2, 16'hffaf, 16'hffb0, 16'hffb1, 16'hffb4, 16'hffe0, 16'hffe1, 16'hffe2,
    16'hffe4, 16'hffe5, 16'hffe6, 16'hffe8, 16'hffe9, 16'hffea, 16'hfff0, 16'hfff4,
    16'hfff9, 16'hfffa, 16'hfffb};

  // Values after reset; undefined registers start at zero
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hcf, 8'h0c, 8'h00, 8'h04, 8'h04};

  // Single-bit manipulation allowed
  localparam bit REG_BIT [NREG] = '{
    0, 0, 0, 0, 1, 1, 1, 1, 0, 1, 0, 1, 0, 0, 1, 0, 1, 0, 1, 1, 1, 0,
    0, 1, 0, 1, 1, 1, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1, 0, 1, 1, 0, 1};

  // Low byte of a 16-bit word pair
  localparam bit REG_WORD [NREG] = '{
    0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0,
    0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 1, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0};

  // Readable; the pin-function switches are write only
  localparam bit REG_RD [NREG] = '{
    0, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1,
    1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1};

  // Accepts one write per reset
  localparam bit REG_ONCE [NREG] = '{
    1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0,
    0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};

endpackage

// file: rtl/psmu_sfr_upper.sv
`timescale 1ns/1ns
`default_nettype none

module psmu_sfr_upper
  import psmu_pkg::*;
(
  input  wire logic                    ref_clk_i,              // CPU clock, 20 MHz
  input  wire logic                    rst_i,                  // Sync reset, high
  input  wire logic                    cpu_rd_i,               // Read request
  input  wire logic                    cpu_wr_i,               // Write request
  input  wire psmu_pkg::psmu_size_t    cpu_size_i,             // Bit, byte or word
  input  wire logic                    cpu_short_i,            // 8-bit sfr form
  input  wire logic [15:0]             cpu_addr_i,             // Byte address
  input  wire logic [2:0]              cpu_bit_i,              // Bit number
  input  wire logic [15:0]             cpu_wdata_i,            // Write data
  input  wire logic [23:0]             irq_req_set_i,          // Event set pulses
  input  wire logic [7:0]              byte_timer_c_count_i,   // Live counter
  input  wire logic [7:0]              async_serial_status_i,  // Live status
  input  wire logic [7:0]              sync_serial_a_shift_i,  // Live shift data
  output logic [15:0]                  cpu_rdata_o,            // Read data
  output logic                         cpu_ack_o,              // Access done
  output logic                         cpu_err_o,              // Access refused
  output logic [NREG*8-1:0]            sfr_q_o,                // All stored bytes
  output logic [15:0]                  wide_timer_b_compare_o  // Compare word
);

  logic [15:0]     eff_addr;       // Address after short-form expansion
  logic            short_bad;      // Short form aimed into the hole
  logic            wr_op;          // Write wins if both strobes are high
  logic            rd_op;
  logic            req;
  logic            dec_hit;        // Table byte addressed
  logic [IDXW-1:0] dec_idx;
  logic            legal;          // Access allowed for this width
  logic [7:0]      cur_byte;       // Current value of the addressed byte
  logic [7:0]      reg_q   [NREG]; // Stored bytes
  logic            wr_en   [NREG]; // Per byte write strobe
  logic [7:0]      wr_val  [NREG]; // Per byte write value
  logic [7:0]      set_val [NREG]; // Per byte hardware set bits

  logic [15:0]     rdata_reg;      // Read data, holds until next read
  logic [15:0]     rdata_next;
  logic            ack_reg;        // One-cycle acknowledge
  logic            ack_next;
  logic            err_reg;        // One-cycle refusal
  logic            err_next;
  logic [15:0]     cmp_reg;        // Word-only compare register
  logic [15:0]     cmp_next;

  // Address decoder
  psmu_decode u_decode (
    .addr_i (eff_addr),
    .hit_o  (dec_hit),
    .idx_o  (dec_idx)
  );

  // One storage cell per table byte
  for (genvar g = 0; g < NREG; g++) begin : g_cell
    // Only request flag bytes see peripheral events
    if (g >= IDX_IRQ_REQ_A_LO && g < IDX_IRQ_REQ_A_LO + IRQ_BYTES) begin : g_irq
      assign set_val[g] = irq_req_set_i[(g - IDX_IRQ_REQ_A_LO)*BYTE_W +: BYTE_W];
    end else begin : g_plain
      assign set_val[g] = 8'h00;
    end
    psmu_byte_reg #(
      .RST_VAL    (REG_RST[g]),
      .WRITE_ONCE (REG_ONCE[g])
    ) u_cell (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .wr_en_i   (wr_en[g]),
      .wr_val_i  (wr_val[g]),
      .set_i     (set_val[g]),
      .q_o       (reg_q[g])
    );
    assign sfr_q_o[g*BYTE_W +: BYTE_W] = reg_q[g];
  end

  // Addressed byte; index 0 when nothing hits, so the value is a don't-care then
  assign cur_byte = reg_q[dec_idx];

  // Request qualification and address expansion
  always_comb begin
    wr_op     = cpu_wr_i;
    rd_op     = cpu_rd_i && !cpu_wr_i;
    req       = cpu_wr_i || cpu_rd_i;
    // Short form always lands in the top page
    eff_addr  = cpu_short_i ? {SFR_PAGE, cpu_addr_i[7:0]} : cpu_addr_i;
    // The short form cannot reach the hole between the two areas
    short_bad = cpu_short_i && (cpu_addr_i[7:0] >= SFR_GAP_LO)
                && (cpu_addr_i[7:0] <= SFR_GAP_HI);
  end

  // Width and direction check
  always_comb begin
    legal = 1'b0;
    if (!req || short_bad) begin
      legal = 1'b0;
    end else if (dec_hit) begin
      case (cpu_size_i)
        PSMU_SZ_BIT:  legal = REG_BIT[dec_idx] && (wr_op || REG_RD[dec_idx]);
        PSMU_SZ_BYTE: legal = wr_op || REG_RD[dec_idx];
        PSMU_SZ_WORD: legal = REG_WORD[dec_idx];
        default:      legal = 1'b0;
      endcase
    end else if (eff_addr == ADDR_CMP_B) begin
      legal = (cpu_size_i == PSMU_SZ_WORD);
    end else if (eff_addr == ADDR_CNT_C || eff_addr == ADDR_ASYNC_STAT
                 || eff_addr == ADDR_SYNC_SHIFT) begin
      // Live peripheral values: byte reads only, writes fall away
      legal = rd_op && (cpu_size_i == PSMU_SZ_BYTE);
    end else begin
      legal = 1'b0;
    end
  end

  // Write steering into the cells, compare word and read data
  always_comb begin
    rdata_next = rdata_reg;
    ack_next   = req && legal;
    err_next   = req && !legal;
    cmp_next   = cmp_reg;
    for (int i = 0; i < NREG; i++) begin
      wr_en[i]  = 1'b0;
      wr_val[i] = reg_q[i];
      if (wr_op && legal && dec_hit) begin
        if (i == int'(dec_idx)) begin
          wr_en[i] = 1'b1;
          case (cpu_size_i)
            // Read-modify-write of one bit; other bits keep their value
            PSMU_SZ_BIT: wr_val[i][cpu_bit_i] = cpu_wdata_i[0];
            default:     wr_val[i] = cpu_wdata_i[7:0];
          endcase
        end
        // High byte of a word pair sits at the next index
        if (i == int'(dec_idx) + 1 && cpu_size_i == PSMU_SZ_WORD) begin
          wr_en[i]  = 1'b1;
          wr_val[i] = cpu_wdata_i[15:8];
        end
      end
    end
    if (wr_op && legal && !dec_hit) begin
      cmp_next = cpu_wdata_i;
    end
    if (rd_op && legal) begin
      if (dec_hit) begin
        case (cpu_size_i)
          PSMU_SZ_BIT:  rdata_next = {15'h0000, cur_byte[cpu_bit_i]};
          PSMU_SZ_WORD: rdata_next = {reg_q[dec_idx + IDXW'(1)], cur_byte};
          // Key wakeup select returns its store; software must not trust it
          default:      rdata_next = {8'h00, cur_byte};
        endcase
      end else if (eff_addr == ADDR_CMP_B) begin
        rdata_next = cmp_reg;
      end else if (eff_addr == ADDR_CNT_C) begin
        rdata_next = {8'h00, byte_timer_c_count_i};
      end else if (eff_addr == ADDR_ASYNC_STAT) begin
        rdata_next = {8'h00, async_serial_status_i};
      end else begin
        rdata_next = {8'h00, sync_serial_a_shift_i};
      end
    end
  end

  // Answer and compare registers; compare content after reset is don't-care
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_reg <= 16'h0000;
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      cmp_reg   <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
      err_reg   <= err_next;
      cmp_reg   <= cmp_next;
    end
  end

  // Outputs straight from flip-flops; nothing combinational reaches the CPU
  assign cpu_rdata_o            = rdata_reg;
  assign cpu_ack_o              = ack_reg;
  assign cpu_err_o              = err_reg;
  assign wide_timer_b_compare_o = cmp_reg;

  // Helper: a write to the first pin-function switch has been taken
  // Lets the write-once check ignore the legal first write
  logic pf_seen_reg;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pf_seen_reg <= 1'b0;
    end else if (wr_en[IDX_PF_A]) begin
      pf_seen_reg <= 1'b1;
    end
  end

  // All checks run on the CPU clock and sleep while reset is held
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  chk_pf_write_once: assert property (
    (pf_seen_reg && wr_en[IDX_PF_A]) |=> $stable(reg_q[IDX_PF_A]))
    else $error("pin-function switch changed after first write");

  chk_mem_size_reset: assert property (
    $fell(rst_i) |-> (reg_q[IDX_MEM_SIZE] == REG_RST[IDX_MEM_SIZE]
                      && reg_q[IDX_XRAM_SIZE] == REG_RST[IDX_XRAM_SIZE]))
    else $error("memory size reset values wrong");

  chk_xram_store: assert property (
    (wr_op && !cpu_short_i && cpu_addr_i == REG_ADDR[IDX_XRAM_SIZE]
     && cpu_size_i == PSMU_SZ_BYTE)
    |=> (reg_q[IDX_XRAM_SIZE] == $past(cpu_wdata_i[7:0]) && cpu_ack_o))
    else $error("expansion RAM size write not stored");

  chk_irq_word_write: assert property (
    (wr_op && !cpu_short_i && cpu_addr_i == REG_ADDR[IDX_IRQ_REQ_A_LO]
     && cpu_size_i == PSMU_SZ_WORD)
    |=> ({reg_q[IDX_IRQ_REQ_A_LO + 1], reg_q[IDX_IRQ_REQ_A_LO]}
         == ($past(cpu_wdata_i) | $past(irq_req_set_i[15:0]))))
    else $error("request flag word write wrong");

  chk_mask_prio_reset: assert property (
    $fell(rst_i) |-> (reg_q[IDX_MASK_A_LO] == 8'hff && reg_q[IDX_PRIO_A_LO] == 8'hff
                      && reg_q[IDX_SSA_CLK_SEL] == REG_RST[IDX_SSA_CLK_SEL]))
    else $error("mask, priority or clock select reset value wrong");

  chk_cmp_word_only: assert property (
    (wr_op && !cpu_short_i && cpu_addr_i == ADDR_CMP_B && cpu_size_i != PSMU_SZ_WORD)
    |=> ($stable(cmp_reg) && cpu_err_o))
    else $error("compare written with wrong width");

  chk_counter_ro: assert property (
    (wr_op && !cpu_short_i && cpu_addr_i == ADDR_CNT_C) |=> (cpu_err_o && !cpu_ack_o))
    else $error("write to read-only counter accepted");

  chk_status_read: assert property (
    (rd_op && !cpu_short_i && cpu_addr_i == ADDR_ASYNC_STAT && cpu_size_i == PSMU_SZ_BYTE)
    |=> (cpu_ack_o && cpu_rdata_o == {8'h00, $past(async_serial_status_i)}))
    else $error("status read data wrong");

  chk_bit_refused: assert property (
    (req && !cpu_short_i && cpu_size_i == PSMU_SZ_BIT
     && (cpu_addr_i == REG_ADDR[IDX_PRESCALE] || cpu_addr_i == REG_ADDR[IDX_OSC_SETTLE]))
    |=> (cpu_err_o && $stable(reg_q[IDX_PRESCALE]) && $stable(reg_q[IDX_OSC_SETTLE])))
    else $error("bit access to byte-only register accepted");

  chk_short_gap: assert property (
    (req && short_bad) |=> (cpu_err_o && $stable(sfr_q_o) && $stable(cmp_reg)))
    else $error("short access into the hole not refused");

  chk_unmapped_quiet: assert property (
    (wr_op && !legal) |=> (cpu_err_o && $stable(cmp_reg)))
    else $error("refused write not flagged");

  // Every taken request gets exactly one answer, so a CPU never waits forever
  chk_answer_once: assert property (
    req |=> (cpu_ack_o != cpu_err_o))
    else $error("request answered by neither or both strobes");

  chk_shift_ro: assert property (
    (wr_op && !cpu_short_i && cpu_addr_i == ADDR_SYNC_SHIFT) |=> (cpu_err_o && !cpu_ack_o))
    else $error("write to read-only shift data accepted");

  // Bit writes are acked and set the addressed bit; the other seven bits are not compared
  chk_clk_sel_bit: assert property (
    (wr_op && !cpu_short_i && cpu_addr_i == REG_ADDR[IDX_SSA_CLK_SEL]
     && cpu_size_i == PSMU_SZ_BIT)
    |=> (cpu_ack_o && reg_q[IDX_SSA_CLK_SEL][$past(cpu_bit_i)] == $past(cpu_wdata_i[0])))
    else $error("bit write to serial clock select lost");

  chk_cpu_clk_bit: assert property (
    (wr_op && !cpu_short_i && cpu_addr_i == REG_ADDR[IDX_CPU_CLK]
     && cpu_size_i == PSMU_SZ_BIT)
    |=> (cpu_ack_o && reg_q[IDX_CPU_CLK][$past(cpu_bit_i)] == $past(cpu_wdata_i[0])))
    else $error("bit write to CPU clock control lost");

  chk_osc_cpu_reset: assert property (
    $fell(rst_i) |-> (reg_q[IDX_OSC_SETTLE] == REG_RST[IDX_OSC_SETTLE]
                      && reg_q[IDX_CPU_CLK] == REG_RST[IDX_CPU_CLK]))
    else $error("clock register reset value wrong");

  // Memory size switch has no bit or word form
  chk_mem_size_byte: assert property (
    (req && !cpu_short_i && cpu_addr_i == REG_ADDR[IDX_MEM_SIZE]
     && cpu_size_i != PSMU_SZ_BYTE)
    |=> (cpu_err_o && $stable(reg_q[IDX_MEM_SIZE])))
    else $error("memory size switch taken with wrong width");

  // Stored value is kept even though software cannot rely on reading it
  chk_key_wakeup_store: assert property (
    (wr_op && !cpu_short_i && cpu_addr_i == REG_ADDR[IDX_KEY_WAKEUP]
     && cpu_size_i == PSMU_SZ_BYTE)
    |=> (cpu_ack_o && reg_q[IDX_KEY_WAKEUP] == $past(cpu_wdata_i[7:0])))
    else $error("key wakeup select write not stored");

  chk_prio_word_read: assert property (
    (rd_op && !cpu_short_i && cpu_addr_i == REG_ADDR[IDX_PRIO_A_LO]
     && cpu_size_i == PSMU_SZ_WORD)
    |=> (cpu_ack_o
         && cpu_rdata_o == $past({reg_q[IDX_PRIO_A_LO + 1], reg_q[IDX_PRIO_A_LO]})))
    else $error("priority flag word read packed wrong");

  // A peripheral event must win over a clearing write in the same cycle
  chk_event_wins: assert property (
    (irq_req_set_i != '0)
    |=> ((sfr_q_o[IDX_IRQ_REQ_A_LO*BYTE_W +: IRQ_W] & $past(irq_req_set_i))
         == $past(irq_req_set_i)))
    else $error("request flag event lost");

  // Main scenarios to cover; the bench reaches the mask word write and the second switch write only

  cov_word_mask: cover property (
    wr_op && legal && cpu_size_i == PSMU_SZ_WORD && dec_idx == IDXW'(IDX_MASK_A_LO));
  cov_pf_second: cover property (pf_seen_reg && wr_en[IDX_PF_A]);
  cov_short_clk: cover property (
    rd_op && legal && cpu_short_i && dec_idx == IDXW'(IDX_CPU_CLK));
  cov_set_clear: cover property (
    wr_en[IDX_IRQ_REQ_A_LO] && set_val[IDX_IRQ_REQ_A_LO] != 8'h00);

endmodule // psmu_sfr_upper

`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// One comparison: counts it and reports a mismatch at once
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp); end end

module tb_top;
  import psmu_pkg::*;

  logic              ref_clk;  // 20 MHz CPU clock
  logic              rst;      // Sync reset, high
  logic              rd;       // Read strobe
  logic              wr;       // Write strobe
  psmu_size_t        size;     // Access width
  logic              sfr_form; // Short 8-bit addressing
  logic [15:0]       addr;     // Byte address
  logic [2:0]        bnum;     // Bit number
  logic [15:0]       wdata;    // Write data
  logic [23:0]       irq_set;  // Event set pulses
  logic [7:0]        cnt_c;    // Live counter value
  logic [7:0]        stat;     // Live status value
  logic [7:0]        shift;    // Live shift value
  logic [15:0]       rdata;    // Read data
  logic              ack;      // Accepted
  logic              err;      // Refused
  logic [NREG*8-1:0] sfr_q;    // All stored bytes
  logic [15:0]       cmp_q;    // Compare word
  int                fails;    // Mismatches
  int                checked;  // Comparisons
  string             msg;      // Name of the running test
  logic [15:0]       rv;       // Last read data

  // Reset values of a spread of registers, one per line of the two tables
  localparam logic [15:0] RA [18] = '{16'hff60, 16'hff61, 16'hff7a, 16'hffa1, 16'hffb1,
    16'hffe0, 16'hffe1, 16'hffe2, 16'hffe4, 16'hffe5, 16'hffe6, 16'hffe8, 16'hffe9,
    16'hffea, 16'hfff0, 16'hfff4, 16'hfffa, 16'hfffb};
  localparam logic [7:0] RV [18] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00,
    8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hcf, 8'h0c, 8'h04, 8'h04};

  psmu_sfr_upper u_dut (
    .ref_clk_i             (ref_clk),
    .rst_i                 (rst),
    .cpu_rd_i              (rd),
    .cpu_wr_i              (wr),
    .cpu_size_i            (size),
    .cpu_short_i           (sfr_form),
    .cpu_addr_i            (addr),
    .cpu_bit_i             (bnum),
    .cpu_wdata_i           (wdata),
    .irq_req_set_i         (irq_set),
    .byte_timer_c_count_i  (cnt_c),
    .async_serial_status_i (stat),
    .sync_serial_a_shift_i (shift),
    .cpu_rdata_o           (rdata),
    .cpu_ack_o             (ack),
    .cpu_err_o             (err),
    .sfr_q_o               (sfr_q),
    .wide_timer_b_compare_o(cmp_q)
  );

  // Clock: half period 25 ns
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // One access: request held for one taking edge, answer looked at just after that edge
  task automatic acc(input logic w, input psmu_size_t sz, input logic s,
                     input logic [15:0] a, input logic [2:0] b, input logic [15:0] d,
                     input logic e);
    @(posedge ref_clk);
    rd       <= ~w;
    wr       <= w;
    size     <= sz;
    sfr_form <= s;
    addr     <= a;
    bnum     <= b;
    wdata    <= d;
    @(posedge ref_clk);
    rd <= 1'b0;
    wr <= 1'b0;
    #1;
    `CHK(err, e)
    `CHK(ack, ~e)
    rv = rdata;
  endtask

  // Byte write with expected refusal flag
  task automatic wrb(input logic [15:0] a, input logic [7:0] d, input logic e);
    acc(1'b1, PSMU_SZ_BYTE, 1'b0, a, 3'd0, {8'h00, d}, e);
  endtask

  // Read of any width and compare of the returned data
  task automatic rdc(input psmu_size_t sz, input logic [15:0] a, input logic [2:0] b,
                     input logic [15:0] x);
    acc(1'b0, sz, 1'b0, a, b, 16'h0000, 1'b0);
    `CHK(rv, x)
  endtask

  // Verdict; the single place where the run ends
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Guard against a hang of the whole run
  initial begin
    #2000000;
    fails++;
    tally_and_finish();
  end

  initial begin
    fails = 0; checked = 0; msg = "reset";
    rst = 1'b1; rd = 1'b0; wr = 1'b0; size = PSMU_SZ_BYTE; sfr_form = 1'b0;
    addr = 16'h0000; bnum = 3'd0; wdata = 16'h0000; irq_set = 24'h000000;
    cnt_c = 8'h00; stat = 8'h00; shift = 8'h00;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    // Reset values read back byte by byte
    for (int i = 0; i < 18; i++) begin
      rdc(PSMU_SZ_BYTE, RA[i], 3'd0, {8'h00, RV[i]});
    end
    $display("test reset values done");
    // Pin-function switch: second write acked but ignored, reads refused
    msg = "write once";
    wrb(16'hff58, 8'h5a, 1'b0);
    wrb(16'hff58, 8'ha5, 1'b0);
    `CHK(sfr_q[7:0], 8'h5a)
    acc(1'b0, PSMU_SZ_BYTE, 1'b0, 16'hff58, 3'd0, 16'h0000, 1'b1);
    $display("test write once done");
    // Size switches take the values software programs; the key wakeup select write and read are only checked for an ack
    msg = "size switches";
    wrb(16'hfff0, 8'hcc, 1'b0);
    rdc(PSMU_SZ_BYTE, 16'hfff0, 3'd0, 16'h00cc);
    wrb(16'hfff4, 8'h09, 1'b0);
    rdc(PSMU_SZ_BYTE, 16'hfff4, 3'd0, 16'h0009);
    wrb(16'hff8f, 8'h3c, 1'b0);
    acc(1'b0, PSMU_SZ_BYTE, 1'b0, 16'hff8f, 3'd0, 16'h0000, 1'b0);
    $display("test size switches done");
    // Word pairs of the interrupt flag registers
    msg = "word pairs";
    acc(1'b1, PSMU_SZ_WORD, 1'b0, 16'hffe0, 3'd0, 16'h1234, 1'b0);
    rdc(PSMU_SZ_BYTE, 16'hffe1, 3'd0, 16'h0012);
    rdc(PSMU_SZ_WORD, 16'hffe0, 3'd0, 16'h1234);
    acc(1'b1, PSMU_SZ_WORD, 1'b0, 16'hffe4, 3'd0, 16'h8001, 1'b0);
    rdc(PSMU_SZ_BYTE, 16'hffe5, 3'd0, 16'h0080);
    acc(1'b1, PSMU_SZ_WORD, 1'b0, 16'hffe8, 3'd0, 16'h00f0, 1'b0);
    rdc(PSMU_SZ_WORD, 16'hffe8, 3'd0, 16'h00f0);
    acc(1'b1, PSMU_SZ_WORD, 1'b0, 16'hffe2, 3'd0, 16'hffff, 1'b1);
    rdc(PSMU_SZ_BIT, 16'hffe0, 3'd2, 16'h0001);
    // Hardware event sets a request flag
    @(posedge ref_clk);
    irq_set <= 24'h010000;
    @(posedge ref_clk);
    irq_set <= 24'h000000;
    rdc(PSMU_SZ_BYTE, 16'hffe2, 3'd0, 16'h0001);
    $display("test word pairs done");
    // Word-only compare register
    msg = "compare";
    acc(1'b1, PSMU_SZ_WORD, 1'b0, 16'hff64, 3'd0, 16'habcd, 1'b0);
    `CHK(cmp_q, 16'habcd)
    rdc(PSMU_SZ_WORD, 16'hff64, 3'd0, 16'habcd);
    wrb(16'hff64, 8'h11, 1'b1);
    `CHK(cmp_q, 16'habcd)
    $display("test compare done");
    // Read-only live values ignore writes and refuse other widths
    msg = "read only";
    @(posedge ref_clk);
    cnt_c <= 8'h3c; stat <= 8'h5a; shift <= 8'hc3;
    wrb(16'hff7a, 8'hff, 1'b1);
    rdc(PSMU_SZ_BYTE, 16'hff7a, 3'd0, 16'h003c);
    wrb(16'hffa1, 8'hff, 1'b1);
    rdc(PSMU_SZ_BYTE, 16'hffa1, 3'd0, 16'h005a);
    wrb(16'hffb2, 8'hff, 1'b1);
    rdc(PSMU_SZ_BYTE, 16'hffb2, 3'd0, 16'h00c3);
    acc(1'b0, PSMU_SZ_BIT, 1'b0, 16'hffa1, 3'd1, 16'h0000, 1'b1);
    $display("test read only done");
    // Bit manipulation: refused on byte-only registers, honoured elsewhere
    msg = "bit access";
    acc(1'b1, PSMU_SZ_BIT, 1'b0, 16'hff61, 3'd0, 16'h0001, 1'b1);
    rdc(PSMU_SZ_BYTE, 16'hff61, 3'd0, 16'h0000);
    acc(1'b1, PSMU_SZ_BIT, 1'b0, 16'hfffa, 3'd7, 16'h0001, 1'b1);
    acc(1'b1, PSMU_SZ_BIT, 1'b0, 16'hfff0, 3'd0, 16'h0000, 1'b1);
    acc(1'b1, PSMU_SZ_BIT, 1'b0, 16'hfffb, 3'd7, 16'h0001, 1'b0);
    rdc(PSMU_SZ_BYTE, 16'hfffb, 3'd0, 16'h0084);
    acc(1'b1, PSMU_SZ_BIT, 1'b0, 16'hffb1, 3'd4, 16'h0000, 1'b0);
    rdc(PSMU_SZ_BYTE, 16'hffb1, 3'd0, 16'h0000);
    $display("test bit access done");
    // Short form, unlisted places, bad widths
    msg = "decode";
    acc(1'b0, PSMU_SZ_BYTE, 1'b1, 16'h12e5, 3'd0, 16'h0000, 1'b0);
    `CHK(rv, 16'h0080)
    acc(1'b0, PSMU_SZ_BYTE, 1'b1, 16'h00d5, 3'd0, 16'h0000, 1'b1);
    acc(1'b0, PSMU_SZ_BYTE, 1'b0, 16'hff66, 3'd0, 16'h0000, 1'b1);
    acc(1'b1, PSMU_SZ_WORD, 1'b0, 16'hff60, 3'd0, 16'hffff, 1'b1);
    acc(1'b1, psmu_size_t'(2'd3), 1'b0, 16'hffe0, 3'd0, 16'hffff, 1'b1);
    rdc(PSMU_SZ_WORD, 16'hffe0, 3'd0, 16'h1234);
    rdc(PSMU_SZ_BYTE, 16'hff60, 3'd0, 16'h0000);
    $display("test decode done");
    // Second reset clears the write-once lock and restores defaults
    msg = "second reset";
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    wrb(16'hff58, 8'h33, 1'b0);
    `CHK(sfr_q[7:0], 8'h33)
    rdc(PSMU_SZ_BYTE, 16'hfff4, 3'd0, 16'h000c);
    $display("test second reset done");
    tally_and_finish();
  end

endmodule // tb_top
`default_nettype wire
